// [logic/wlss_defs.svh]
// offsets, field positions, reset values and limits of the weight level
// and setpoint supervisor; included by the design only.
`ifndef WLSS_DEFS_SVH
`define WLSS_DEFS_SVH

// ****************************************************************
// register offsets (byte addresses, low 8 bits of haddr)
// ****************************************************************
`define WLSS_OFF_CTRL 8'h00
`define WLSS_OFF_STATUS 8'h04
`define WLSS_OFF_OUTMAP 8'h08
`define WLSS_OFF_ACC_LO 8'h0C
`define WLSS_OFF_ACC_HI 8'h60
// groups of four words, channel index in haddr[3:2]
`define WLSS_GRP_LVL_CFG 4'h1
`define WLSS_GRP_LVL_VAL 4'h2
`define WLSS_GRP_LVL_HYS 4'h3
`define WLSS_GRP_SP_VAL 4'h4
`define WLSS_GRP_SP_SRC 4'h5

// ****************************************************************
// field positions
// ****************************************************************
`define WLSS_CTRL_CLR_ACC 0
`define WLSS_CTRL_ARM_LSB 4
`define WLSS_CTRL_CANCEL_LSB 8
`define WLSS_STAT_ABOVE_LSB 0
`define WLSS_STAT_ARMED_LSB 4
`define WLSS_STAT_DONE_LSB 8
`define WLSS_LVL_POL_BIT 3
`define WLSS_MAP_EN_BIT 3
`define WLSS_MAP_SP_BIT 2

// ****************************************************************
// source codes
// ****************************************************************
`define WLSS_SRC_OFF 3'h0
`define WLSS_SRC_NET 3'h1
`define WLSS_SRC_GROSS 3'h2
`define WLSS_SRC_DISP 3'h3
`define WLSS_SRC_ABS_NET 3'h4
`define WLSS_SRC_ABS_GROSS 3'h5
`define WLSS_SRC_ABS_DISP 3'h6
`define WLSS_SRC_NONE 3'h7

// ****************************************************************
// reset values and accumulator limit (10^13 milli-units)
// ****************************************************************
`define WLSS_RST_WORD 32'h0000_0000
`define WLSS_RST_CFG 4'h0
`define WLSS_RST_MAP 16'h0000
`define WLSS_ACC_LIMIT 48'h0918_4E72_A000

`endif

// [logic/wlss_pkg.sv]
// types shared by the weight level and setpoint supervisor.
// needs nothing from the defs header; only the design includes it.
`default_nettype none

package wlss_pkg;
   typedef logic [2:0] wlss_src_t;             // weight source code
   typedef logic signed [31:0] wlss_word_t;    // signed weight word
   typedef logic signed [32:0] wlss_wide_t;    // weight with abs headroom
   typedef logic [47:0] wlss_acc_t;            // accumulated total
endpackage

`default_nettype wire

// [logic/wlss_top.sv]
// weight level and setpoint supervisor with an AHB-Lite register slave.
// assumes weight samples in milli-units, synchronous to i_clk, and a
// single AHB-Lite master issuing single word transfers.
//
// Notes on behaviour
// R1: four level channels, each own level
// R2: any output may follow a level channel
// R3: source off, net or gross fixed
// R4: displayed source follows gross/net display
// R5: absolute sources compare magnitude only
// R6: polarity picks active above or below
// R7: hysteresis width signed, minus means negative
// R8: one threshold is level, differ by width
// R9: other threshold above or below by width
// R10: status shows hysteresis result, not outputs
// R11: four one-shot setpoints, armed by master
// R12: master loads setpoint values before arming
// R13: arming activates the assigned output at once
// R14: setpoint maps to any output, selects source
// R15: exceeding disarms, flags done, drops output
// R16: cancel disarms and drops the output
// R17: loading or arming clears the done flag
// R18: any armed setpoint inhibits zero-tracking
// R19: each print adds displayed weight to total
// R20: total wraps by subtracting the limit
// R21: clear all totals, or clear/overwrite one
// R22: re-evaluate on each sample, hold between
//
// The AHB-Lite slave port and the address map were decided locally.
`include "wlss_defs.svh"
`default_nettype none

module wlss_top
   import wlss_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   input wire logic i_sample_valid,
   input wire logic [31:0] i_gross,
   input wire logic [31:0] i_net,
   input wire logic i_net_shown,
   input wire logic i_print,
   output logic [3:0] o_dout,
   output logic o_zt_inhibit
);

   // ****************************************************************
   // weight selection
   // ****************************************************************
   // picks the compared weight; off gives zero
   function automatic wlss_wide_t pick_w(input wlss_src_t src,
         input wlss_word_t g, input wlss_word_t n, input logic shown);
      wlss_wide_t gw;
      wlss_wide_t nw;
      wlss_wide_t dw;
      wlss_wide_t r;
      gw = wlss_wide_t'(g);
      nw = wlss_wide_t'(n);
      dw = shown ? nw : gw;                       // see R4
      case (src)
         `WLSS_SRC_NET: r = nw;                   // see R3
         `WLSS_SRC_GROSS: r = gw;                 // see R3
         `WLSS_SRC_DISP: r = dw;
         `WLSS_SRC_ABS_NET: r = (nw < 0) ? -nw : nw;     // see R5
         `WLSS_SRC_ABS_GROSS: r = (gw < 0) ? -gw : gw;   // see R5
         `WLSS_SRC_ABS_DISP: r = (dw < 0) ? -dw : dw;    // see R5
         default: r = '0;
      endcase
      return r;
   endfunction

   // codes 1 to 6 select a weight, 0 and 7 leave the channel off
   function automatic logic src_on(input wlss_src_t src);
      return (src != `WLSS_SRC_OFF) && (src != `WLSS_SRC_NONE);
   endfunction

   // ****************************************************************
   // bus address phase
   // ****************************************************************
   logic wr_q;
   logic [7:0] addr_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_mux;
   wire take = i_hsel & i_hready & i_htrans[1];
   wire wr = wr_q;
   wire [3:0] wgrp = addr_q[7:4];
   wire [1:0] widx = addr_q[3:2];
   wire [3:0] rgrp = i_haddr[7:4];
   wire [1:0] ridx = i_haddr[3:2];
   wire wr_ctrl = wr & (addr_q == `WLSS_OFF_CTRL);
   wire wr_map = wr & (addr_q == `WLSS_OFF_OUTMAP);
   wire wr_acc_lo = wr & (addr_q == `WLSS_OFF_ACC_LO);
   wire wr_acc_hi = wr & (addr_q == `WLSS_OFF_ACC_HI);
   wire wr_lcfg = wr & (wgrp == `WLSS_GRP_LVL_CFG);
   wire wr_lval = wr & (wgrp == `WLSS_GRP_LVL_VAL);
   wire wr_lhys = wr & (wgrp == `WLSS_GRP_LVL_HYS);
   wire wr_spv = wr & (wgrp == `WLSS_GRP_SP_VAL);
   wire wr_sps = wr & (wgrp == `WLSS_GRP_SP_SRC);
   wire clr_acc = wr_ctrl & i_hwdata[`WLSS_CTRL_CLR_ACC];
   wire [3:0] arm = wr_ctrl ? i_hwdata[`WLSS_CTRL_ARM_LSB +: 4] : 4'h0;
   wire [3:0] cancel =
      wr_ctrl ? i_hwdata[`WLSS_CTRL_CANCEL_LSB +: 4] : 4'h0;

   // zero-wait slave, always OKAY
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_hrdata = hrdata_q;

   // address phase capture and read data register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_q <= 1'b0;
         addr_q <= 8'h00;
         hrdata_q <= `WLSS_RST_WORD;
      end else begin
         wr_q <= take & i_hwrite;
         if (take) begin
            addr_q <= {i_haddr[7:2], 2'b00};
            hrdata_q <= i_hwrite ? `WLSS_RST_WORD : rd_mux;
         end
      end
   end

   // ****************************************************************
   // configuration storage
   // ****************************************************************
   logic [3:0] lvl_cfg_q [4];
   wlss_word_t lvl_val_q [4];
   wlss_word_t lvl_hys_q [4];
   wlss_word_t sp_val_q [4];
   wlss_src_t sp_src_q [4];
   logic [15:0] map_q;

   // software writes into the channel tables
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         map_q <= `WLSS_RST_MAP;
         for (int i = 0; i < 4; i++) begin
            lvl_cfg_q[i] <= `WLSS_RST_CFG;
            lvl_val_q[i] <= `WLSS_RST_WORD;
            lvl_hys_q[i] <= `WLSS_RST_WORD;
            sp_val_q[i] <= `WLSS_RST_WORD;
            sp_src_q[i] <= `WLSS_SRC_OFF;
         end
      end else begin
         if (wr_map) map_q <= i_hwdata[15:0];
         if (wr_lcfg) lvl_cfg_q[widx] <= i_hwdata[3:0];
         if (wr_lval) lvl_val_q[widx] <= i_hwdata;
         if (wr_lhys) lvl_hys_q[widx] <= i_hwdata;    // see R7
         if (wr_spv) sp_val_q[widx] <= i_hwdata;
         if (wr_sps) sp_src_q[widx] <= i_hwdata[2:0];  // see R14
      end
   end

   // ****************************************************************
   // level and setpoint channels
   // ****************************************************************
   logic [3:0] above_q;
   logic [3:0] above_d;
   logic [3:0] armed_q;
   logic [3:0] done_q;
   logic [3:0] hit;
   logic [3:0] lvl_on;
   logic signed [33:0] hi_th [4];
   logic signed [33:0] lo_th [4];
   logic signed [33:0] lw [4];

   for (genvar c = 0; c < 4; c++) begin : g_ch
      wire wlss_src_t lsrc = lvl_cfg_q[c][2:0];
      wire logic signed [33:0] lvl = 34'(lvl_val_q[c]);
      wire logic signed [33:0] hys = 34'(lvl_hys_q[c]);
      wire wlss_wide_t sw = pick_w(sp_src_q[c], i_gross, i_net,
         i_net_shown);
      assign lw[c] = 34'(pick_w(lsrc, i_gross, i_net, i_net_shown));
      assign lvl_on[c] = src_on(lsrc);                  // see R3
      // one threshold at the level, the other offset by the width
      assign hi_th[c] = (hys < 0) ? lvl : lvl + hys;   // see R8, R9
      assign lo_th[c] = (hys < 0) ? lvl + hys : lvl;   // see R8, R9
      // rise above the upper, fall below the lower threshold
      assign above_d[c] = !lvl_on[c] ? 1'b0 :           // see R3
         above_q[c] ? (lw[c] >= lo_th[c]) : (lw[c] > hi_th[c]);
      // armed setpoint passed by its weight on this sample
      assign hit[c] = i_sample_valid & armed_q[c] &
         src_on(sp_src_q[c]) &
         (sw > wlss_wide_t'(sp_val_q[c]));              // see R15
   end

   // per-sample level evaluation, held between samples
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) above_q <= 4'h0;
      else if (i_sample_valid) above_q <= above_d;      // see R1, R22
   end

   // one-shot setpoints: cancel beats arm, a fresh arm beats a hit
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         armed_q <= 4'h0;
         done_q <= 4'h0;
      end else begin
         armed_q <= (armed_q & ~hit & ~cancel)
            | (arm & ~cancel);                           // see R11, R16
         // set by a hit wins over a load or arm clear
         done_q <= (done_q & ~(arm | (wr_spv ? 4'(1 << widx) : 4'h0)))
            | hit;                                       // see R15, R17
      end
   end

   assign o_zt_inhibit = |armed_q;                      // see R18

   // ****************************************************************
   // digital outputs
   // ****************************************************************
   // nibble per output: enable, level/setpoint, channel index
   for (genvar o = 0; o < 4; o++) begin : g_out
      wire [3:0] m = map_q[4*o +: 4];
      wire [1:0] k = m[1:0];
      wire lvl_act = lvl_on[k] &
         (lvl_cfg_q[k][`WLSS_LVL_POL_BIT] ? ~above_q[k] : above_q[k]);
      assign o_dout[o] = m[`WLSS_MAP_EN_BIT] &
         (m[`WLSS_MAP_SP_BIT] ? armed_q[k] : lvl_act);  // see R2, R6, R13
   end

   // ****************************************************************
   // accumulated displayed weight
   // ****************************************************************
   logic [47:0] acc_q;
   wire logic signed [49:0] disp_w =
      50'(pick_w(`WLSS_SRC_DISP, i_gross, i_net, i_net_shown));
   wire logic signed [49:0] acc_sum = $signed({2'b00, acc_q}) + disp_w;
   wire logic signed [49:0] lim = $signed({2'b00, `WLSS_ACC_LIMIT});
   // wrap into range: subtract past the limit, add back below zero
   wire logic [47:0] acc_next = (acc_sum >= lim) ? 48'(acc_sum - lim) :
      (acc_sum < 0) ? 48'(acc_sum + lim) : 48'(acc_sum);  // see R20

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) acc_q <= 48'h0000_0000_0000;
      else if (clr_acc) acc_q <= 48'h0000_0000_0000;     // see R21
      else if (wr_acc_lo) acc_q[31:0] <= i_hwdata;       // see R21
      else if (wr_acc_hi) acc_q[47:32] <= i_hwdata[15:0];
      else if (i_print) acc_q <= acc_next;               // see R19
   end

   // ****************************************************************
   // read mux
   // ****************************************************************
   always_comb begin
      rd_mux = `WLSS_RST_WORD;
      case (rgrp)
         4'h0: begin
            case (i_haddr[7:0])
               `WLSS_OFF_STATUS:
                  rd_mux = {20'h0_0000, done_q, armed_q, above_q}; // see R10
               `WLSS_OFF_OUTMAP: rd_mux = {16'h0000, map_q};
               `WLSS_OFF_ACC_LO: rd_mux = acc_q[31:0];
               default: rd_mux = `WLSS_RST_WORD;
            endcase
         end
         `WLSS_GRP_LVL_CFG: rd_mux = {28'h000_0000, lvl_cfg_q[ridx]};
         `WLSS_GRP_LVL_VAL: rd_mux = lvl_val_q[ridx];
         `WLSS_GRP_LVL_HYS: rd_mux = lvl_hys_q[ridx];
         `WLSS_GRP_SP_VAL: rd_mux = sp_val_q[ridx];
         `WLSS_GRP_SP_SRC: rd_mux = {29'h0000_0000, sp_src_q[ridx]};
         4'h6: rd_mux = (i_haddr[7:0] == `WLSS_OFF_ACC_HI) ?
            {16'h0000, acc_q[47:32]} : `WLSS_RST_WORD;
         default: rd_mux = `WLSS_RST_WORD;
      endcase
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   // arm of setpoint 0 with no cancel and no hit beside it
   sequence s_arm0;
      arm[0] && !cancel[0] && !hit[0];
   endsequence
   // armed setpoint 0 passed by its weight, no fresh arm
   sequence s_hit0;
      hit[0] && !arm[0];
   endsequence
   // setpoint 0 armed, done clear, zero-tracking held off
   sequence s_armed0;
      armed_q[0] && !done_q[0] ##0 o_zt_inhibit;
   endsequence
   // level 0 in use, below, and sample past the upper threshold
   sequence s_rise0;
      i_sample_valid && lvl_on[0] && !above_q[0] && lw[0] > hi_th[0];
   endsequence

   // setpoint handling
   a_arm_sets_out: assert property ( // see R13, R17, R18
      s_arm0 |=> s_armed0)
      else $error("arm did not take");
   a_hit_disarms: assert property ( // see R15
      s_hit0 |=> !armed_q[0] && done_q[0])
      else $error("setpoint hit not handled");
   a_cancel_drops: assert property ( // see R16
      cancel[0] |=> !armed_q[0])
      else $error("cancel did not disarm");
   a_done_holds: assert property ( // see R17
      done_q[0] && !arm[0] && !wr_spv |=> done_q[0])
      else $error("done flag lost");
   a_zt_idle: assert property ( // see R18
      armed_q == 4'h0 |-> !o_zt_inhibit)
      else $error("zero-tracking inhibited while idle");
   a_sp_out: assert property ( // see R13, R14
      map_q[11:8] == 4'hC |-> o_dout[2] == armed_q[0])
      else $error("output not following setpoint");

   // level handling
   a_level_hold: assert property ( // see R22
      !i_sample_valid |=> $stable(above_q))
      else $error("level changed without sample");
   a_level_off: assert property ( // see R3
      i_sample_valid && !lvl_on[0] |=> !above_q[0])
      else $error("disabled level set");
   a_hys_keep: assert property ( // see R8
      i_sample_valid && above_q[0] && lvl_on[0] && lw[0] >= lo_th[0]
      |=> above_q[0])
      else $error("hysteresis not kept");
   a_level_rise: assert property ( // see R8, R9
      s_rise0 |=> above_q[0])
      else $error("level did not rise");
   a_out_follow: assert property ( // see R2
      map_q[3:0] == 4'h8 && lvl_on[0] &&
      lvl_cfg_q[0][`WLSS_LVL_POL_BIT] == 1'b0 |-> o_dout[0] == above_q[0])
      else $error("output not following level");

   // accumulator handling
   a_acc_range: assert property ( // see R20
      i_print && !wr && acc_q < `WLSS_ACC_LIMIT
      |=> acc_q < `WLSS_ACC_LIMIT)
      else $error("total beyond limit");
   a_acc_clear: assert property ( // see R21
      clr_acc |=> acc_q == 48'h0000_0000_0000)
      else $error("total not cleared");
   a_acc_hold: assert property ( // see R19
      !i_print && !wr |=> $stable(acc_q))
      else $error("total changed without print");

endmodule // wlss_top

`default_nettype wire

// [sim/wlss_master.sv]
// AHB-Lite single master model driving the supervisor's register slave.
// assumes one slave whose hreadyout is fed straight back as hready.
`default_nettype none

module wlss_master (
   input wire logic i_clk,
   input wire logic i_hready,
   input wire logic [31:0] i_hrdata,
   output logic o_hsel,
   output logic [31:0] o_haddr,
   output logic [1:0] o_htrans,
   output logic o_hwrite,
   output logic [2:0] o_hsize,
   output logic [31:0] o_hwdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus at time zero, word size only
   initial begin
      o_hsel = 1'b1;
      o_haddr = 32'h0000_0000;
      o_htrans = 2'b00;
      o_hwrite = 1'b0;
      o_hsize = 3'b010;
      o_hwdata = 32'h0000_0000;
   end

   // one single transfer: address phase, then data phase
   task automatic xfer(input logic w, input logic [31:0] a,
         input logic [31:0] d, output logic [31:0] r);
      @(posedge i_clk);
      o_htrans <= 2'b10;
      o_haddr <= a;
      o_hwrite <= w;
      @(posedge i_clk);
      while (i_hready !== 1'b1) @(posedge i_clk);
      o_htrans <= 2'b00;
      o_hwdata <= d;
      @(posedge i_clk);
      while (i_hready !== 1'b1) @(posedge i_clk);
      r = i_hrdata;
      o_hwdata <= ~d; // no stale data once released
   endtask
endmodule // wlss_master

`default_nettype wire

// [sim/wlss_top_tb.sv]
// self-checking bench for the weight level and setpoint supervisor.
// assumes the design and the master model are compiled beforehand.
`default_nettype none

module wlss_top_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic i_sample_valid = 1'b0;
   logic [31:0] i_gross = 32'h0000_0000;
   logic [31:0] i_net = 32'h0000_0000;
   logic i_net_shown = 1'b0;
   logic i_print = 1'b0;
   logic [3:0] dout;
   logic zt;
   logic [31:0] rd;
   int err_total = 0;
   int checks = 0;

   always #20 i_clk = ~i_clk;

   wlss_top wlss_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp),
      .o_hrdata(hrdata), .i_sample_valid(i_sample_valid),
      .i_gross(i_gross), .i_net(i_net), .i_net_shown(i_net_shown),
      .i_print(i_print), .o_dout(dout), .o_zt_inhibit(zt));

   wlss_master wlss_master_inst (.i_clk(i_clk), .i_hready(hreadyout),
      .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
      .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
      .o_hwdata(hwdata));

   // ****************************************************************
   // helper tasks
   // ****************************************************************
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      wlss_master_inst.xfer(1'b1, a, d, rd);
      #1;
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      wlss_master_inst.xfer(1'b0, a, 32'h0000_0000, rd);
      chk(rd, e);
      chk(hresp, 1'b0);
   endtask

   // status fields armed and done only
   task automatic st(input logic [7:0] e);
      wlss_master_inst.xfer(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
      chk(rd[11:4], e);
   endtask

   // one sample (p=0) or print (p=1) strobe of one cycle
   task automatic pulse(input logic [31:0] g, n, input logic s, p);
      @(posedge i_clk);
      i_gross <= g;
      i_net <= n;
      i_net_shown <= s;
      if (p) i_print <= 1'b1;
      else i_sample_valid <= 1'b1;
      @(posedge i_clk);
      i_print <= 1'b0;
      i_sample_valid <= 1'b0;
      #1;
   endtask

   // sample, then level status and outputs
   task automatic step(input logic [31:0] g, n, input logic s,
         input logic [3:0] es, input logic [3:0] ed);
      pulse(g, n, s, 1'b0);
      chk(dout, ed);
      rdc(32'h0000_0004, {28'h000_0000, es});
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ****************************************************************
   // watchdog and main sequence
   // ****************************************************************
   initial begin
      #100000;
      err_total++;
      finish_test();
   end

   initial begin
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      #1;
      chk({dout, zt}, 5'h00);
      rdc(32'h0000_0004, 32'h0000_0000);
      // ch0 gross above, lvl 100 hys +10
      wr(32'h0000_0010, 32'h0000_0002);
      wr(32'h0000_0020, 32'h0000_0064);
      wr(32'h0000_0030, 32'h0000_000A);
      // ch1 abs net, active below, lvl 100 hys -10
      wr(32'h0000_0014, 32'h0000_000C);
      wr(32'h0000_0024, 32'h0000_0064);
      wr(32'h0000_0034, 32'hFFFF_FFF6);
      wr(32'h0000_0018, 32'h0000_0003);
      // out0 lvl0, out1 lvl1, out2 sp0, out3 lvl2
      wr(32'h0000_0008, 32'h0000_AC98);
      step(32'h0000_0069, 32'h0000_0000, 1'b0, 4'h4, 4'hA);
      step(32'h0000_006F, 32'hFFFF_FF9B, 1'b0, 4'h7, 4'h9);
      step(32'h0000_0069, 32'hFFFF_FFA1, 1'b1, 4'h3, 4'h1);
      step(32'h0000_0063, 32'h0000_0059, 1'b1, 4'h4, 4'hA);
      step(32'hFFFF_FFFB, 32'hFFFF_FFFB, 1'b0, 4'h0, 4'h2);
      // net, abs gross, abs displayed, and code 7 off with level -5
      wr(32'h0000_0010, 32'h0000_0001);
      wr(32'h0000_0014, 32'h0000_0005);
      wr(32'h0000_0018, 32'h0000_0006);
      wr(32'h0000_001C, 32'h0000_0007);
      wr(32'h0000_002C, 32'hFFFF_FFFB);
      step(32'hFFFF_FF6A, 32'h0000_0078, 1'b0, 4'h7, 4'hB);
      step(32'h0000_0028, 32'hFFFF_FF9C, 1'b1, 4'h4, 4'h8);
      // setpoint 0 on gross at 500
      wr(32'h0000_0040, 32'h0000_01F4);
      wr(32'h0000_0050, 32'h0000_0002);
      wr(32'h0000_0000, 32'h0000_0010);
      chk({dout[2], zt}, 2'b11);
      pulse(32'h0000_01F4, 32'h0000_0000, 1'b0, 1'b0);
      st(8'h01);
      pulse(32'h0000_01F5, 32'h0000_0000, 1'b0, 1'b0);
      chk({dout[2], zt}, 2'b00);
      st(8'h10);
      wr(32'h0000_0000, 32'h0000_0010);
      st(8'h01);
      wr(32'h0000_0000, 32'h0000_0100);
      chk({dout[2], zt}, 2'b00);
      st(8'h00);
      wr(32'h0000_0044, 32'hFFFF_FFFB);
      wr(32'h0000_0054, 32'h0000_0007);
      wr(32'h0000_0000, 32'h0000_00F0);
      st(8'h0F);
      pulse(32'h0000_0064, 32'h0000_0000, 1'b0, 1'b0);
      st(8'h0F);
      wr(32'h0000_0000, 32'h0000_0F00);
      wr(32'h0000_0000, 32'h0000_0010);
      pulse(32'h0000_0258, 32'h0000_0000, 1'b0, 1'b0);
      st(8'h10);
      wr(32'h0000_0040, 32'h0000_03E8);
      st(8'h00);
      // accumulator just below the limit, then wrap
      wr(32'h0000_000C, 32'h4E72_9FFF);
      wr(32'h0000_0060, 32'h0000_0918);
      pulse(32'h0000_0005, 32'h0000_0000, 1'b0, 1'b1);
      rdc(32'h0000_000C, 32'h0000_0004);
      rdc(32'h0000_0060, 32'h0000_0000);
      pulse(32'h0000_0009, 32'h0000_07D0, 1'b1, 1'b1);
      rdc(32'h0000_000C, 32'h0000_07D4);
      wr(32'h0000_0000, 32'h0000_0001);
      rdc(32'h0000_000C, 32'h0000_0000);
      // unmapped place and write-only control
      wr(32'h0000_0070, 32'hFFFF_FFFF);
      rdc(32'h0000_0070, 32'h0000_0000);
      rdc(32'h0000_0000, 32'h0000_0000);
      // reset in mid-run with a setpoint armed
      wr(32'h0000_0000, 32'h0000_0010);
      chk(zt, 1'b1);
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      @(posedge i_clk);
      #1;
      chk({dout, zt}, 5'h00);
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      #1;
      rdc(32'h0000_0004, 32'h0000_0000);
      rdc(32'h0000_0008, 32'h0000_0000);
      finish_test();
   end
endmodule // wlss_top_tb

`default_nettype wire
